// file: src/match_regs.vh
// Register map, field positions, reset values and timing constants
// for the port pattern-match interrupt unit.
// Assumes inclusion by its bare name from design files under src/.
`ifndef MATCH_REGS_VH
`define MATCH_REGS_VH

// ==========================================================
// Register offsets (register index on the plain port)
`define ADDR_W            3
`define OFF_MASK          3'h0
`define OFF_PATTERN       3'h1
`define OFF_CONTROL       3'h2
`define OFF_IRQ_STATUS    3'h3
`define OFF_IRQ_MASK      3'h4
`define OFF_PORT_VALUE    3'h5

// ==========================================================
// Control register fields
`define CTL_FLAG_BIT      0
`define CTL_POL_BIT       1
`define CTL_ENABLE_BIT    2
`define CTL_IE_BIT        3

// ==========================================================
// Interrupt status bits
`define IRQ_MATCH_BIT     0
`define IRQ_LOST_BIT      1
`define IRQ_W             2

// ==========================================================
// Reset values
`define RST_MASK          8'h00
`define RST_PATTERN       8'hff
`define RST_CONTROL       4'h0
`define RST_IRQ           2'h0
`define ZERO_BYTE         8'h00

// ==========================================================
// Timing: condition must hold longer than six core clocks
`define HOLD_CLOCKS       6
`define HOLD_W            3
`define HOLD_ZERO         3'h0
`define HOLD_ONE          3'h1

`endif

// file: src/match_hold.v
// Persistence filter: qualifies the raw compare result.
// Assumes a raw condition synchronous to clk.
`timescale 1ns/1ps
`include "match_regs.vh"

module match_hold (
  input  wire clk,
  input  wire rstn,
  input  wire cond,
  output reg  held
);

  reg [`HOLD_W-1:0] cnt_q;

  // ==========================================================
  // Counter
  // count hold time
  always @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= `HOLD_ZERO;
      held  <= 1'b0;
    end else if (!cond) begin
      cnt_q <= `HOLD_ZERO;
      held  <= 1'b0;
    end else begin
      if (cnt_q != `HOLD_CLOCKS)
        cnt_q <= cnt_q + `HOLD_ONE;
      // Fires on the seventh consecutive clock of the condition
      held <= (cnt_q == `HOLD_CLOCKS);
    end
  end

endmodule // match_hold

// file: src/port_pattern_match_interrupt.v
// Port pattern-match interrupt unit: masked compare of an 8-bit port
// against a pattern, sticky flag, interrupt and wake request.
// Assumes port pins and the register port are synchronous to clk.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "match_regs.vh"

module port_pattern_match_interrupt (
  input  wire                clk,
  input  wire                rstn,
  input  wire [7:0]          port_in,
  input  wire [`ADDR_W-1:0]  addr,
  input  wire [7:0]          wdata,
  input  wire                wr,
  input  wire                rd,
  output reg  [7:0]          rdata,
  output reg                 irq,
  output reg                 wake
);

  reg  [7:0]         match_mask_reg_q;
  reg  [7:0]         match_pattern_reg_q;
  reg                match_flag_q;
  reg                compare_polarity_select_q;
  reg                enable_q;
  reg                int_enable_q;
  reg  [`IRQ_W-1:0]  irq_status_q;
  reg  [`IRQ_W-1:0]  irq_mask_q;
  reg  [7:0]         rdata_d;
  reg                flag_d;
  reg  [`IRQ_W-1:0]  status_d;
  wire [7:0]         diff_bits;
  wire               equal;
  wire               cond;
  wire               held;
  wire               set_flag;
  wire               wr_ctl;
  wire [`IRQ_W-1:0]  ev;
  genvar             i;

  // ==========================================================
  // Compare
  // masked bitwise compare
  // Unselected pins force their difference bit to zero
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      assign diff_bits[i] = (port_in[i] ^ match_pattern_reg_q[i])
                          & match_mask_reg_q[i];
    end
  endgenerate
  assign equal     = (diff_bits == `ZERO_BYTE);
  assign cond = enable_q & (compare_polarity_select_q ? ~equal : equal);

  match_hold u_hold (
    .clk  (clk),
    .rstn (rstn),
    .cond (cond),
    .held (held)
  );

  assign set_flag = held & enable_q;
  assign wr_ctl   = wr & (addr == `OFF_CONTROL);

  // ==========================================================
  // Match flag: set wins over a clearing write
  // sticky flag
  always @* begin
    flag_d = match_flag_q;
    if (wr_ctl & ~wdata[`CTL_FLAG_BIT])
      flag_d = 1'b0;
    if (set_flag)
      flag_d = 1'b1;
  end

  // ==========================================================
  // Interrupt status: match event only; the lost bit is tied to zero
  assign ev[`IRQ_MATCH_BIT] = set_flag & ~match_flag_q;
  assign ev[`IRQ_LOST_BIT]  = 1'b0;

  always @* begin
    status_d = irq_status_q;
    if (wr & (addr == `OFF_IRQ_STATUS))
      status_d = status_d & ~wdata[`IRQ_W-1:0];
    status_d = status_d | ev;
  end

  // ==========================================================
  // Register writes
  always @(posedge clk) begin
    if (!rstn) begin
      match_mask_reg_q          <= `RST_MASK;
      match_pattern_reg_q       <= `RST_PATTERN;
      compare_polarity_select_q <= 1'b0;
      enable_q                  <= 1'b0;
      int_enable_q              <= 1'b0;
      match_flag_q              <= 1'b0;
      irq_status_q              <= `RST_IRQ;
      irq_mask_q                <= `RST_IRQ;
    end else begin
      match_flag_q <= flag_d;
      irq_status_q <= status_d;
      if (wr) begin
        case (addr)
          `OFF_MASK:    match_mask_reg_q    <= wdata;
          `OFF_PATTERN: match_pattern_reg_q <= wdata;
          `OFF_CONTROL: begin
            compare_polarity_select_q <= wdata[`CTL_POL_BIT];
            enable_q                  <= wdata[`CTL_ENABLE_BIT];
            int_enable_q              <= wdata[`CTL_IE_BIT];
          end
          `OFF_IRQ_MASK: irq_mask_q <= wdata[`IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Read path: data valid the cycle after the strobe
  always @* begin
    rdata_d = `ZERO_BYTE;
    case (addr)
      `OFF_MASK:       rdata_d = match_mask_reg_q;
      `OFF_PATTERN:    rdata_d = match_pattern_reg_q;
      `OFF_CONTROL: begin
        rdata_d[`CTL_FLAG_BIT]   = match_flag_q;
        rdata_d[`CTL_POL_BIT]    = compare_polarity_select_q;
        rdata_d[`CTL_ENABLE_BIT] = enable_q;
        rdata_d[`CTL_IE_BIT]     = int_enable_q;
      end
      `OFF_IRQ_STATUS: rdata_d[`IRQ_W-1:0] = irq_status_q;
      `OFF_IRQ_MASK:   rdata_d[`IRQ_W-1:0] = irq_mask_q;
      `OFF_PORT_VALUE: rdata_d = port_in;
      default:         rdata_d = `ZERO_BYTE;
    endcase
  end

  // ==========================================================
  // Outputs from flip-flops
  always @(posedge clk) begin
    if (!rstn) begin
      rdata <= `ZERO_BYTE;
      irq   <= 1'b0;
      wake  <= 1'b0;
    end else begin
      rdata <= rd ? rdata_d : `ZERO_BYTE;
      // flag term gated by interrupt enable; mask gates the status bits
      irq   <= (match_flag_q & int_enable_q)
             | (|(irq_status_q & irq_mask_q));
      // wake tracks the enabled flag, no clock gating here
      wake  <= match_flag_q & int_enable_q;
    end
  end

endmodule // port_pattern_match_interrupt

// file: sim/keypad_model.sv
// Keypad model: one switch to ground per port pin, with pull-ups.
// Assumes the bench drives keys as levels, high meaning pressed.
`timescale 1ns/1ps
// ==========
// Keypad
module keypad_model (
  input  wire       clk,
  input  wire [7:0] keys,
  output reg  [7:0] port_in = 8'hff
);
  // pulled-up pins
  // A released pin reads high, so all ones is the idle pattern
  always @(posedge clk) port_in <= ~keys;
endmodule // keypad_model

// file: sim/match_chk_assertions.sv
// Port-level checker for the pattern-match unit.
// Assumes clk and rstn are the design's own clock and reset.
`timescale 1ns/1ps
`include "match_regs.vh"
// ==========
// Checker
module match_chk (
  input wire       clk,
  input wire       rstn,
  input wire [7:0] port_in,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       irq,
  input wire       wake
);
  reg ie_q;
  // Shadow of the interrupt enable, as software last wrote it
  always @(posedge clk)
    if (!rstn) ie_q <= 1'b0;
    else if (wr && addr == `OFF_CONTROL) ie_q <= wdata[`CTL_IE_BIT];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_port_read: assert property ($past(rd) && $past(addr) ==
    `OFF_PORT_VALUE && $past(port_in, 2) == $past(port_in)
    |-> rdata == $past(port_in)) else $error("port value read wrong");
  a_rdata_pulse: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not zero");
  a_wake_irq: assert property (wake |-> irq)
    else $error("wake without irq");
  a_wake_sticky: assert property (wake && !wr && !$past(wr) |=> wake)
    else $error("wake fell without write");
  a_irq_sticky: assert property (irq && !wr && !$past(wr) |=> irq)
    else $error("irq fell without write");
  a_wake_enable: assert property (wake |-> ie_q || $past(ie_q))
    else $error("wake with enable clear");
  a_wake_rise: assert property ($rose(wake) |-> $past(ie_q))
    else $error("wake rose with enable clear");
  // Enable write plus seven held clocks cannot finish in eight cycles
  a_reset_quiet: assert property ($rose(rstn) |-> !irq [*8])
    else $error("irq too soon after reset");
  c_wake: cover property ($rose(wake));
  c_irq_clear: cover property ($fell(irq));
  c_port_read: cover property ($past(rd) && $past(addr) == `OFF_PORT_VALUE);
endmodule // match_chk
bind port_pattern_match_interrupt match_chk u_chk (.clk, .rstn, .port_in,
  .addr, .wdata, .wr, .rd, .rdata, .irq, .wake);

// file: sim/port_pattern_match_interrupt_tb.sv
// Testbench: keypad model on the port, registers over the plain port.
// Assumes design files, keypad model and checker are compiled first.
`timescale 1ns/1ps
`include "match_regs.vh"
// ==========
// Bench
module port_pattern_match_interrupt_tb;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg  [7:0] keys = 8'h00;
  reg  [2:0] addr = 3'h0;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  wire [7:0] port_in;
  wire [7:0] rdata;
  wire       irq;
  wire       wake;
  integer    bad_count = 0;
  integer    compares = 0;
  initial forever #4 clk = ~clk;
  keypad_model pad (.clk, .keys, .port_in);
  port_pattern_match_interrupt DUT (.clk, .rstn, .port_in, .addr, .wdata,
    .wr, .rd, .rdata, .irq, .wake);
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      bad_count = bad_count + 1;
    end
  endtask
  task stop_test;
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wreg(input [2:0] a, input [7:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rreg(input [2:0] a, input [7:0] e);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task press(input [7:0] k, input integer n);
    @(posedge clk); keys <= k;
    repeat (n) @(posedge clk);
    keys <= 8'h00;
    repeat (12) @(posedge clk);
  endtask
  task t_reset;
    rreg(`OFF_MASK, 8'h00);
    rreg(`OFF_PATTERN, 8'hff);
    rreg(`OFF_CONTROL, 8'h00);
    rreg(`OFF_PORT_VALUE, 8'hff);
    rreg(3'h7, 8'h00);
  endtask
  task t_keypad;
    wreg(`OFF_MASK, 8'h0f);
    wreg(`OFF_CONTROL, 8'h0e);
    press(8'h80, 20);
    #1 chk(irq, 8'h00);
    press(8'h01, 6);
    #1 chk(irq, 8'h00);
    press(8'h01, 7);
    #1 chk(irq, 8'h01);
    chk(wake, 8'h01);
    rreg(`OFF_CONTROL, 8'h0f);
    wreg(`OFF_CONTROL, 8'h0e);
    repeat (2) @(posedge clk);
    #1 chk(irq, 8'h00);
  endtask
  task t_equal;
    wreg(`OFF_CONTROL, 8'h00);
    wreg(`OFF_MASK, 8'hff);
    wreg(`OFF_PATTERN, 8'h05);
    wreg(`OFF_IRQ_STATUS, 8'h03);
    wreg(`OFF_CONTROL, 8'h04);
    press(8'hfa, 8);
    #1 chk(irq, 8'h00);
    rreg(`OFF_CONTROL, 8'h05);
    wreg(`OFF_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk(irq, 8'h01);
    rreg(`OFF_IRQ_STATUS, 8'h01);
    rreg(`OFF_IRQ_MASK, 8'h01);
    wreg(`OFF_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk(irq, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_keypad;
    t_equal;
    stop_test;
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count = bad_count + 1;
    stop_test;
  end
endmodule // port_pattern_match_interrupt_tb
